/* File: rtl/uic_pkg.sv */
// constants for the first serial port option and irq routing block
package uic_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] UIC_OFS_IRQ_STAT = 8'h00;
	localparam logic [7:0] UIC_OFS_IRQ_MASK = 8'h04;
	localparam logic [7:0] UIC_OFS_OPTION = 8'hf0;

	// ---------------------------------------------------------------
	// option register fields and reset values
	// ---------------------------------------------------------------
	localparam int UIC_BIT_MIDI = 0;
	localparam int UIC_BIT_HSPEED = 1;
	localparam int UIC_RSV_LSB = 2;
	localparam int UIC_RSV_MSB = 6;
	localparam int UIC_BIT_SHARE = 7;
	localparam logic [7:0] UIC_OPTION_RST = 8'h00;
	localparam logic [1:0] UIC_STAT_RST = 2'h0;
	localparam logic [1:0] UIC_MASK_RST = 2'h0;

	// ---------------------------------------------------------------
	// interrupt status bit positions
	// ---------------------------------------------------------------
	localparam int UIC_EV_UART1 = 0;
	localparam int UIC_EV_UART2 = 1;
	localparam int UIC_NUM_EV = 2;
endpackage

/* File: rtl/uic_top.sv */
// option register and shared irq routing for the first serial port
//
// Summary of operation
// [R1] option bit 0 enables midi rate
// [R2] option bit 1 enables high speed
// [R3] software writes zeros to bits 6..2
// [R4] share clear: each uart drives own pin
// [R5] share set: both pins carry merged value
// [R6] gate bit clear hides uart interrupt
// [R7] option reg cleared only by hard reset
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module uic_top #(
	parameter int ADDR_W = 8
) (
	// clock and hard reset
	input wire logic pclk,
	input wire logic presetn,
	// soft reset, active low, leaves the option register alone
	input wire logic soft_rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// uart interrupt requests and their aux output gate bits
	input wire logic uart1_irq,
	input wire logic uart1_aux_output_irq_gate,
	input wire logic uart2_irq,
	input wire logic uart2_aux_output_irq_gate,
	// host irq pins, output value and output enable
	output logic irq_pin1_out,
	output logic irq_pin1_oe,
	output logic irq_pin2_out,
	output logic irq_pin2_oe,
	// option outputs to the uart
	output logic midi_enable,
	output logic high_speed_enable,
	// block interrupt
	output logic irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] option;
		logic [uic_pkg::UIC_NUM_EV-1:0] stat;
		logic [uic_pkg::UIC_NUM_EV-1:0] mask;
		logic pin1_out;
		logic pin1_oe;
		logic pin2_out;
		logic pin2_oe;
		logic irq;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} uic_state_t;

	uic_state_t s_r;
	uic_state_t s_nxt;

	logic g1;
	logic g2;
	logic share;
	logic setup;
	logic wr_done;
	logic mapped;
	logic [uic_pkg::UIC_NUM_EV-1:0] ev;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		share = s_r.option[uic_pkg::UIC_BIT_SHARE];
		// [R6] gate by aux bit
		g1 = uart1_aux_output_irq_gate & uart1_irq;
		g2 = uart2_aux_output_irq_gate & uart2_irq;
		ev = '0;
		ev[uic_pkg::UIC_EV_UART1] = g1;
		ev[uic_pkg::UIC_EV_UART2] = g2;
		setup = psel & ~penable;
		wr_done = psel & penable & s_r.ready & pwrite & ~s_r.slverr;
		mapped = (paddr[7:0] == uic_pkg::UIC_OFS_OPTION)
			| (paddr[7:0] == uic_pkg::UIC_OFS_IRQ_STAT)
			| (paddr[7:0] == uic_pkg::UIC_OFS_IRQ_MASK);
		if (ADDR_W > 8)
		begin
			mapped = mapped & ~(|(paddr >> 8));
		end

		// apb answer is prepared in setup and shown in the first access cycle
		s_nxt.ready = setup;
		s_nxt.slverr = setup & ~mapped;
		if (setup)
		begin
			s_nxt.rdata = 32'h0000_0000;
			if (paddr[7:0] == uic_pkg::UIC_OFS_OPTION)
			begin
				s_nxt.rdata[7:0] = s_r.option;
			end
			else if (paddr[7:0] == uic_pkg::UIC_OFS_IRQ_STAT)
			begin
				s_nxt.rdata[uic_pkg::UIC_NUM_EV-1:0] = s_r.stat;
			end
			else if (paddr[7:0] == uic_pkg::UIC_OFS_IRQ_MASK)
			begin
				s_nxt.rdata[uic_pkg::UIC_NUM_EV-1:0] = s_r.mask;
			end
		end

		// [R1] [R2] option register write, bits 6..2 stored as written
		if (wr_done && pstrb[0] && paddr[7:0] == uic_pkg::UIC_OFS_OPTION)
		begin
			s_nxt.option = pwdata[7:0];
		end
		if (wr_done && pstrb[0] && paddr[7:0] == uic_pkg::UIC_OFS_IRQ_MASK)
		begin
			s_nxt.mask = pwdata[uic_pkg::UIC_NUM_EV-1:0];
		end

		// write one to clear; a new event in the same cycle wins
		if (wr_done && pstrb[0] && paddr[7:0] == uic_pkg::UIC_OFS_IRQ_STAT)
		begin
			s_nxt.stat = s_r.stat & ~pwdata[uic_pkg::UIC_NUM_EV-1:0];
		end
		s_nxt.stat = s_nxt.stat | ev;

		// soft reset clears the event logic only
		if (!soft_rst_n)
		begin
			s_nxt.stat = uic_pkg::UIC_STAT_RST;
			s_nxt.mask = uic_pkg::UIC_MASK_RST;
		end
		s_nxt.irq = |(s_nxt.stat & s_nxt.mask);

		// pins lag inputs by one cycle so that they come from flops
		if (!share)
		begin
			// [R4] separate pins
			s_nxt.pin1_oe = uart1_aux_output_irq_gate;
			s_nxt.pin1_out = uart1_aux_output_irq_gate & uart1_irq;
			s_nxt.pin2_oe = uart2_aux_output_irq_gate;
			s_nxt.pin2_out = uart2_aux_output_irq_gate & uart2_irq;
		end
		else
		begin
			// [R5] merged pins
			s_nxt.pin1_oe = uart1_aux_output_irq_gate | uart2_aux_output_irq_gate;
			s_nxt.pin1_out = g1 | g2;
			s_nxt.pin2_oe = s_nxt.pin1_oe;
			s_nxt.pin2_out = s_nxt.pin1_out;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// [R7] only the hard reset restores the option default
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r.option <= uic_pkg::UIC_OPTION_RST;
			s_r.stat <= uic_pkg::UIC_STAT_RST;
			s_r.mask <= uic_pkg::UIC_MASK_RST;
			s_r.pin1_out <= 1'b0;
			s_r.pin1_oe <= 1'b0;
			s_r.pin2_out <= 1'b0;
			s_r.pin2_oe <= 1'b0;
			s_r.irq <= 1'b0;
			s_r.rdata <= 32'h0000_0000;
			s_r.ready <= 1'b0;
			s_r.slverr <= 1'b0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.rdata;
	assign pready = s_r.ready;
	assign pslverr = s_r.slverr;
	assign irq_pin1_out = s_r.pin1_out;
	assign irq_pin1_oe = s_r.pin1_oe;
	assign irq_pin2_out = s_r.pin2_out;
	assign irq_pin2_oe = s_r.pin2_oe;
	assign midi_enable = s_r.option[uic_pkg::UIC_BIT_MIDI];
	assign high_speed_enable = s_r.option[uic_pkg::UIC_BIT_HSPEED];
	assign irq = s_r.irq;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// [R1] midi follows written bit
	midi_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(psel && penable && pready && pwrite && !pslverr && pstrb[0]
			&& paddr[7:0] == uic_pkg::UIC_OFS_OPTION)
		|=> (midi_enable == $past(pwdata[0])))
		else $error("midi enable did not follow write");

	// [R2] high speed follows written bit
	hspeed_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		(psel && penable && pready && pwrite && !pslverr && pstrb[0]
			&& paddr[7:0] == uic_pkg::UIC_OFS_OPTION)
		|=> (high_speed_enable == $past(pwdata[1])))
		else $error("high speed enable did not follow write");

	// sampled presetn keeps pin checks except gate_hide_a off the release edge, where the flops still reset
	// [R4] separate pin one
	pin1_sep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		presetn && !s_r.option[uic_pkg::UIC_BIT_SHARE] ##1 $stable(s_r.option)
		|-> (irq_pin1_oe == $past(uart1_aux_output_irq_gate))
			&& (!irq_pin1_oe || irq_pin1_out == $past(uart1_irq)))
		else $error("pin one wrong in separate mode");

	// [R4] separate pin two
	pin2_sep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		presetn && !s_r.option[uic_pkg::UIC_BIT_SHARE] ##1 $stable(s_r.option)
		|-> (irq_pin2_oe == $past(uart2_aux_output_irq_gate))
			&& (!irq_pin2_oe || irq_pin2_out == $past(uart2_irq)))
		else $error("pin two wrong in separate mode");

	// [R5] shared pins equal and merged
	pin_share_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		presetn && s_r.option[uic_pkg::UIC_BIT_SHARE] ##1 $stable(s_r.option)
		|-> (irq_pin1_out == irq_pin2_out) && (irq_pin1_oe == irq_pin2_oe)
			&& (irq_pin1_oe == ($past(uart1_aux_output_irq_gate)
				|| $past(uart2_aux_output_irq_gate))))
		else $error("shared pins disagree");

	// [R6] gated uart cannot raise shared pin
	gate_hide_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(s_r.option[uic_pkg::UIC_BIT_SHARE] && !uart1_aux_output_irq_gate
			&& !(uart2_aux_output_irq_gate && uart2_irq) && uart1_irq)
		##1 $stable(s_r.option) |-> !irq_pin1_out)
		else $error("gated uart reached the pin");

	// [R7] soft reset keeps the option register
	soft_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(!soft_rst_n && !(psel && penable && pready && pwrite))
		|=> $stable(s_r.option))
		else $error("soft reset disturbed the option register");

	irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq |-> |(s_r.stat & s_r.mask))
		else $error("irq without unmasked status");

	// [R6] gated uart kept off its own pin
	pin1_hide_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(presetn && !s_r.option[uic_pkg::UIC_BIT_SHARE] && !uart1_aux_output_irq_gate)
		##1 $stable(s_r.option) |-> (!irq_pin1_oe && !irq_pin1_out))
		else $error("gated uart one drove its pin");

	// [R5] shared line undriven with both gates clear
	share_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(presetn && s_r.option[uic_pkg::UIC_BIT_SHARE] && !uart1_aux_output_irq_gate
			&& !uart2_aux_output_irq_gate)
		##1 $stable(s_r.option) |-> (!irq_pin1_oe && !irq_pin2_oe))
		else $error("shared line driven with both gates clear");

	// [R5] any enabled request raises both pins
	share_merge_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(presetn && s_r.option[uic_pkg::UIC_BIT_SHARE]
			&& ((uart1_aux_output_irq_gate && uart1_irq)
				|| (uart2_aux_output_irq_gate && uart2_irq)))
		##1 $stable(s_r.option) |-> (irq_pin1_out && irq_pin2_out))
		else $error("shared line missed a request");

	// [R6] enabled request latches its status bit
	stat_set_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(presetn && soft_rst_n && uart1_aux_output_irq_gate && uart1_irq)
		|=> s_r.stat[uic_pkg::UIC_EV_UART1])
		else $error("uart one request not latched");

	// write one clears a quiet status bit
	stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && psel && penable && pready && pwrite && !pslverr && pstrb[0]
			&& paddr[7:0] == uic_pkg::UIC_OFS_IRQ_STAT && pwdata[0]
			&& !(uart1_aux_output_irq_gate && uart1_irq))
		|=> !s_r.stat[uic_pkg::UIC_EV_UART1])
		else $error("status bit survived its clear");

	// soft reset empties status and mask
	soft_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && !soft_rst_n) |=> (s_r.stat == '0) && (s_r.mask == '0))
		else $error("soft reset left status or mask set");

	// apb answer stands for exactly one cycle
	ready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && psel && !penable) |=> pready ##1 !pready)
		else $error("ready did not pulse once");

	// unmapped address answered with an error
	slverr_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && psel && !penable && paddr[7:0] != uic_pkg::UIC_OFS_OPTION
			&& paddr[7:0] != uic_pkg::UIC_OFS_IRQ_STAT
			&& paddr[7:0] != uic_pkg::UIC_OFS_IRQ_MASK)
		|=> pslverr)
		else $error("unmapped address not refused");

endmodule

/* File: verif/uic_host_pic.sv */
// host interrupt controller side of the two irq pins
`timescale 1ns/100ps
module uic_host_pic (
	// clock
	input wire logic pclk,
	// pins from the device
	input wire logic pin1_out,
	input wire logic pin1_oe,
	input wire logic pin2_out,
	input wire logic pin2_oe,
	// levels seen by the host
	output logic lvl1,
	output logic lvl2
);
	// ---------------------------------------------------------------
	// pin resolution
	// ---------------------------------------------------------------
	logic [1:0] last_r = 2'h0;
	// no pull on these lines: an undriven pin shows the inverse of its last level
	assign lvl1 = pin1_oe ? pin1_out : ~last_r[0];
	assign lvl2 = pin2_oe ? pin2_out : ~last_r[1];
	always_ff @(posedge pclk)
	begin
		last_r <= {lvl2, lvl1};
	end
endmodule

/* File: verif/uart_irq_share_config_test.sv */
// self-checking bench for the serial option and irq routing block
`timescale 1ns/100ps
module uart_irq_share_config_test;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic pclk = 1'b0, presetn = 1'b0, soft_rst_n = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, r;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, irq, midi_enable, high_speed_enable, se;
	logic u1 = 1'b0, g1 = 1'b0, u2 = 1'b0, g2 = 1'b0;
	logic o1, e1, o2, e2, l1, l2;
	logic [7:0] opt;
	int err_total = 0, checks = 0, cyc = 0, seed = 32'h9dcac58b;
	always #5 pclk = ~pclk;
	uic_top dut (.pclk(pclk), .presetn(presetn), .soft_rst_n(soft_rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .uart1_irq(u1),
		.uart1_aux_output_irq_gate(g1), .uart2_irq(u2), .uart2_aux_output_irq_gate(g2),
		.irq_pin1_out(o1), .irq_pin1_oe(e1), .irq_pin2_out(o2), .irq_pin2_oe(e2),
		.midi_enable(midi_enable), .high_speed_enable(high_speed_enable), .irq(irq));
	uic_host_pic pic (.pclk(pclk), .pin1_out(o1), .pin1_oe(e1), .pin2_out(o2),
		.pin2_oe(e2), .lvl1(l1), .lvl2(l2));
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// expected {oe1, out1, oe2, out2}, outputs masked by their enables
	function logic [3:0] pins(input logic s, a1, i1, a2, i2);
		logic m;
		m = (a1 & i1) | (a2 & i2);
		pins = s ? {a1 | a2, m, a1 | a2, m} : {a1, a1 & i1, a2, a2 & i2};
	endfunction
	task end_of_test;
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// the tests need about 420 cycles
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			end_of_test();
		end
	end
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, uic_pkg::UIC_OFS_OPTION, 32'h0);
		chk(q, {24'h0, uic_pkg::UIC_OPTION_RST});
		chk({midi_enable, high_speed_enable}, 2'h0);
		$display("reset test done");
		for (int i = 0; i < 64; i++)
		begin
			r = (i < 32) ? i : $random(seed);
			// reserved field written as zeros
			opt = {r[4], 5'h00, r[6:5]};
			{g1, u1, g2, u2} <= r[3:0];
			apb(1'b1, uic_pkg::UIC_OFS_OPTION, {24'h0, opt});
			apb(1'b0, uic_pkg::UIC_OFS_OPTION, 32'h0);
			chk(q, {24'h0, opt});
			chk({midi_enable, high_speed_enable}, {opt[0], opt[1]});
			chk({e1, e1 & l1, e2, e2 & l2}, pins(opt[7], g1, u1, g2, u2));
		end
		$display("routing test done");
		soft_rst_n <= 1'b0;
		@(posedge pclk);
		soft_rst_n <= 1'b1;
		apb(1'b0, uic_pkg::UIC_OFS_OPTION, 32'h0);
		chk(q, {24'h0, opt});
		{g1, u1, g2, u2} <= 4'hc;
		apb(1'b1, uic_pkg::UIC_OFS_IRQ_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b1);
		u1 <= 1'b0;
		apb(1'b1, uic_pkg::UIC_OFS_IRQ_STAT, 32'h1);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b0);
		{g1, u1, g2, u2} <= 4'h3;
		repeat (3) @(posedge pclk);
		apb(1'b0, uic_pkg::UIC_OFS_IRQ_STAT, 32'h0);
		chk(q, 32'h2);
		chk(irq, 1'b0);
		apb(1'b1, 8'h08, 32'h5);
		chk(se, 1'b1);
		chk(q, 32'h0);
		$display("interrupt test done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, uic_pkg::UIC_OFS_OPTION, 32'h0);
		chk(q, {24'h0, uic_pkg::UIC_OPTION_RST});
		$display("hard reset test done");
		end_of_test();
	end
endmodule
